//--- rtl/acd_map.svh
// offsets, field positions, reset values and codes of the command decoder
`ifndef ACD_MAP_SVH
`define ACD_MAP_SVH
`define ACD_CFG3_OFS    8'h15
`define ACD_STAT_OFS    8'h16
`define ACD_BCNT_LO_OFS 8'h17
`define ACD_BCNT_HI_OFS 8'h18
`define ACD_ECNT_0_OFS  8'h19
`define ACD_ECNT_1_OFS  8'h1a
`define ACD_ECNT_2_OFS  8'h1b
`define ACD_CFG3_RST    8'ha7
`define ACD_C3_NOSPD    3
`define ACD_C3_WDOFF    4
`define ACD_C3_CORR     5
`define ACD_C3_TEST     6
`define ACD_C3_SCRUB    7
`define ACD_ST_AUTO     4
`define ACD_ST_FSYNC    5
`define ACD_ST_PHOK     6
`define ACD_ST_LOCK     7
`define ACD_SUB_FINE1   8'h00
`define ACD_SUB_FINE2   8'h01
`define ACD_SUB_COARSE  8'h02
`define ACD_SUB_CTRL    8'h03
`define ACD_SUB_ERRDMP  8'h04
`define ACD_SUB_CFGDMP  8'h05
`define ACD_SUB_RESET   8'h06
`define ACD_Q_EXT       4'h0
`define ACD_Q_ERR_BASE  4'h1
`define ACD_Q_CFG_BASE  4'h5
`define ACD_ERR_LAST    3'h3
`define ACD_CFG_LAST    3'h5
`define ACD_FD_BASE     4
`endif

//--- rtl/acd_pkg.sv
// types of the addressed command decoder
package acd_pkg;
  typedef enum logic [1:0] {
    ACD_IDLE = 2'b00,
    ACD_ERR  = 2'b01,
    ACD_CFG  = 2'b10
  } acd_dump_t;
  typedef struct packed {
    logic        valid;
    logic [13:0] target;
    logic        scope;
    logic [7:0]  sub;
    logic [7:0]  data;
  } acd_frame_t;
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
    logic [3:0] qual;
    logic       strobe;
  } acd_out_t;
  typedef struct packed {
    logic [15:0] single;
    logic [7:0]  dbl;
    logic [7:0]  seu;
  } acd_errcnt_t;
  typedef struct packed {
    acd_out_t    out;
    acd_dump_t   dump;
    logic [2:0]  step;
    logic [7:0]  fine1;
    logic [7:0]  fine2;
    logic [7:0]  coarse;
    logic [7:0]  control;
    logic [13:0] chip_id;
    logic        id_load;
    logic [11:0] bcnt;
    logic [23:0] ecnt;
    logic [2:0]  t1;
    logic [2:0]  t2;
    logic [2:0]  t3;
    logic [2:0]  seen;
    logic        rst_tgl;
    logic        ack_tgl;
    logic [11:0] hold_b;
    logic [23:0] hold_e;
  } acd_link_st_t;
  typedef struct packed {
    logic [7:0]  cfg3;
    logic [5:0]  p1;
    logic [5:0]  p2;
    logic [5:0]  p3;
    logic [5:0]  pin;
    logic        fd_on;
    logic [11:0] fd_cnt;
    logic        auto_rst;
    logic [1:0]  t1;
    logic [1:0]  t2;
    logic [1:0]  t3;
    logic [1:0]  seen;
    logic        clr_b;
    logic        clr_e;
    logic        req;
    logic [11:0] sh_b;
    logic [23:0] sh_e;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        st_wr;
  } acd_core_st_t;
endpackage : acd_pkg

//--- rtl/acd_decoder.sv
// addressed command decoder with counters, tuning and health registers
// Operation
// - frequency detection ends after 2^(n+4) cycles without low-frequency, n from bits 2:0
// - tuning bit 3 set suppresses the speed-up after a loop reset
// - tuning bit 4 set turns the timeout guard off
// - scrubber runs unless both redundant enable bits are zero
// - 12-bit crossing count advances every link clock cycle
// - crossing count clears on clear command, register write, initialisation
// - 24-bit trigger count advances on each trigger accept
// - trigger count clears on clear command, register write, initialisation
// - health bit 4 flags a forced reset by the timeout guard
// - health bit 5 shows channel B frame synchronisation
// - health bit 6 shows phase shifters working
// - health bit 7 shows clock and data recovery locked
// - health register stores nothing, bits 3:0 zero, write fires a pulse
// - frame accepted only on 14-bit identifier match or identifier 0; 8-bit index, 8-bit data
// - scope 0 means internal, 1 external; decoded accordingly
// - external frame drives index and data buses with a strobe
// - internal index 0..3 writes fine1, fine2, coarse, control
// - internal index 4, 5, 6 run error readout, setting readout, reset
// - identifier 0 is accepted by every receiver
// - error readout gives four strobed bytes, qualifiers 1 to 4
// - setting readout gives six strobed bytes, qualifiers 5 to 10
// - reset command starts the full initialisation
// - identifier loaded from boot memory or strap pins at initialisation
`timescale 1ns/1ps
`default_nettype none
`include "acd_map.svh"
module acd_decoder (
  // core clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             ARST_N,
  // recovered link clock
  input  wire logic             LINK_CLK,
  // link side, same clock
  input  wire acd_pkg::acd_frame_t  FRAME,
  input  wire logic             CROSSING_COUNT_CLEAR_CMD,
  input  wire logic             TRIGGER_COUNT_CLEAR_CMD,
  input  wire logic             TRIGGER_ACCEPT,
  input  wire acd_pkg::acd_errcnt_t ERR_COUNTS,
  // identifier sources, static around initialisation
  input  wire logic [15:0]      ID_STRAP,
  input  wire logic             ID_BOOT_SEL,
  input  wire logic [13:0]      ID_BOOT,
  // external command bus
  output acd_pkg::acd_out_t     CMD_OUT,
  // timing registers and counters
  output logic [7:0]            FINE_DELAY1,
  output logic [7:0]            FINE_DELAY2,
  output logic [7:0]            COARSE_DELAY,
  output logic [7:0]            CONTROL,
  output logic [13:0]           CHIP_ID,
  output logic [11:0]           CROSSING_COUNT,
  output logic [23:0]           TRIGGER_COUNT,
  // register port of the two-wire side
  input  wire logic             REG_WR_EN,
  input  wire logic             REG_RD_EN,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  output logic [7:0]            REG_RDATA,
  output logic                  REG_RVALID,
  output logic                  STATUS_WRITE_PULSE,
  // analog and supervision pins
  input  wire logic             FREQ_LOW,
  input  wire logic             LOOP_RESET,
  input  wire logic             WDOG_TIMEOUT,
  input  wire logic             FRAME_SYNC,
  input  wire logic             PHASE_OK,
  input  wire logic             CDR_LOCK,
  input  wire logic             SCRUBBER_ON_PRIMARY,
  output logic                  FREQ_DETECT_ON,
  output logic                  FREQ_SPEEDUP_ON,
  output logic                  TIMEOUT_GUARD_ON,
  output logic                  SCRUBBER_ON,
  output logic                  INBOUND_CORRECTION_ON,
  output logic                  TEST_PINS_ON
);
  import acd_pkg::*;

  acd_link_st_t l_q, l_d;
  acd_core_st_t c_q, c_d;

  // toggle events from core to link: 0 crossing clear, 1 trigger clear, 2 snapshot
  logic [2:0] l_ev;
  logic       hit;
  assign l_ev = (l_q.t2 ~^ l_q.t3) & (l_q.t3 ^ l_q.seen);
  assign hit  = FRAME.valid && l_q.dump == ACD_IDLE && !l_q.id_load &&
                (FRAME.target == l_q.chip_id || FRAME.target == 14'h0000);

  always_comb begin
    l_d            = l_q;
    l_d.out.strobe = 1'b0;
    l_d.t1         = {c_q.req, c_q.clr_e, c_q.clr_b};
    l_d.t2         = l_q.t1;
    l_d.t3         = l_q.t2;
    l_d.seen       = l_q.seen ^ l_ev;
    l_d.bcnt       = l_q.bcnt + 12'h001;
    if (TRIGGER_ACCEPT) begin
      l_d.ecnt = l_q.ecnt + 24'h000001;
    end
    // clear beats the increment in the same cycle
    if (CROSSING_COUNT_CLEAR_CMD || l_ev[0]) begin
      l_d.bcnt = 12'h000;
    end
    if (TRIGGER_COUNT_CLEAR_CMD || l_ev[1]) begin
      l_d.ecnt = 24'h000000;
    end
    if (l_ev[2]) begin
      l_d.hold_b  = l_q.bcnt;
      l_d.hold_e  = l_q.ecnt;
      l_d.ack_tgl = ~l_q.ack_tgl;
    end
    if (l_q.id_load) begin
      l_d.id_load = 1'b0;
      l_d.chip_id = ID_BOOT_SEL ? ID_BOOT : ID_STRAP[13:0];
      l_d.bcnt    = 12'h000;
      l_d.ecnt    = 24'h000000;
    end
    case (l_q.dump)
      ACD_IDLE: begin
        if (hit && FRAME.scope) begin
          l_d.out.index  = FRAME.sub;
          l_d.out.data   = FRAME.data;
          l_d.out.qual   = `ACD_Q_EXT;
          l_d.out.strobe = 1'b1;
        end else if (hit) begin
          if (FRAME.sub == `ACD_SUB_FINE1) begin
            l_d.fine1 = FRAME.data;
          end else if (FRAME.sub == `ACD_SUB_FINE2) begin
            l_d.fine2 = FRAME.data;
          end else if (FRAME.sub == `ACD_SUB_COARSE) begin
            l_d.coarse = FRAME.data;
          end else if (FRAME.sub == `ACD_SUB_CTRL) begin
            l_d.control = FRAME.data;
          end else if (FRAME.sub == `ACD_SUB_ERRDMP) begin
            l_d.dump = ACD_ERR;
            l_d.step = 3'h0;
          end else if (FRAME.sub == `ACD_SUB_CFGDMP) begin
            l_d.dump = ACD_CFG;
            l_d.step = 3'h0;
          end else if (FRAME.sub == `ACD_SUB_RESET) begin
            // full reset: timing regs, counters, identifier, core side
            l_d.id_load = 1'b1;
            l_d.fine1   = 8'h00;
            l_d.fine2   = 8'h00;
            l_d.coarse  = 8'h00;
            l_d.control = 8'h00;
            l_d.rst_tgl = ~l_q.rst_tgl;
          end
          // indices above 6 fall through untouched
        end
      end
      ACD_ERR: begin
        l_d.out.strobe = 1'b1;
        l_d.out.qual   = `ACD_Q_ERR_BASE + {1'b0, l_q.step};
        if (l_q.step == 3'h0) begin
          l_d.out.data = ERR_COUNTS.single[7:0];
        end else if (l_q.step == 3'h1) begin
          l_d.out.data = ERR_COUNTS.single[15:8];
        end else if (l_q.step == 3'h2) begin
          l_d.out.data = ERR_COUNTS.dbl;
        end else begin
          l_d.out.data = ERR_COUNTS.seu;
        end
        l_d.step = l_q.step + 3'h1;
        if (l_q.step == `ACD_ERR_LAST) begin
          l_d.dump = ACD_IDLE;
        end
      end
      ACD_CFG: begin
        l_d.out.strobe = 1'b1;
        l_d.out.qual   = `ACD_Q_CFG_BASE + {1'b0, l_q.step};
        if (l_q.step == 3'h0) begin
          l_d.out.data = l_q.fine1;
        end else if (l_q.step == 3'h1) begin
          l_d.out.data = l_q.fine2;
        end else if (l_q.step == 3'h2) begin
          l_d.out.data = l_q.coarse;
        end else if (l_q.step == 3'h3) begin
          l_d.out.data = l_q.control;
        end else if (l_q.step == 3'h4) begin
          l_d.out.data = l_q.chip_id[7:0];
        end else begin
          l_d.out.data = {2'b00, l_q.chip_id[13:8]};
        end
        l_d.step = l_q.step + 3'h1;
        if (l_q.step == `ACD_CFG_LAST) begin
          l_d.dump = ACD_IDLE;
        end
      end
      default: begin
        l_d.dump = ACD_IDLE;
      end
    endcase
  end

  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      l_q         <= '0;
      l_q.dump    <= ACD_IDLE;
      l_q.id_load <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

  // core side: pins pass three flops, a level counts once stages two and three agree
  logic [1:0]  c_ev;
  logic [5:0]  pin_raw;
  logic [11:0] fd_limit;
  logic        lr_rise;
  assign pin_raw  = {CDR_LOCK, PHASE_OK, FRAME_SYNC, WDOG_TIMEOUT, LOOP_RESET, FREQ_LOW};
  assign c_ev     = (c_q.t2 ~^ c_q.t3) & (c_q.t3 ^ c_q.seen);
  assign fd_limit = 12'((13'h0001 << (`ACD_FD_BASE + c_q.cfg3[2:0])) - 13'h0001);
  assign lr_rise  = (c_q.p2[1] ~^ c_q.p3[1]) & c_q.p3[1] & ~c_q.pin[1];

  always_comb begin
    c_d        = c_q;
    c_d.p1     = pin_raw;
    c_d.p2     = c_q.p1;
    c_d.p3     = c_q.p2;
    c_d.pin    = (c_q.p3 & (c_q.p2 ~^ c_q.p3)) | (c_q.pin & (c_q.p2 ^ c_q.p3));
    c_d.t1     = {l_q.ack_tgl, l_q.rst_tgl};
    c_d.t2     = c_q.t1;
    c_d.t3     = c_q.t2;
    c_d.seen   = c_q.seen ^ c_ev;
    c_d.rvalid = 1'b0;
    c_d.st_wr  = 1'b0;
    // one snapshot in flight; hold is stable once its ack is seen
    if (c_q.req == c_q.seen[1]) begin
      c_d.req = ~c_q.req;
    end
    if (c_ev[1]) begin
      c_d.sh_b = l_q.hold_b;
      c_d.sh_e = l_q.hold_e;
    end
    if (c_q.fd_on) begin
      if (c_q.pin[0]) begin
        c_d.fd_cnt = 12'h000;
      end else if (c_q.fd_cnt >= fd_limit) begin
        // a shorter period written mid-phase still ends it at once
        c_d.fd_on = 1'b0;
      end else begin
        c_d.fd_cnt = c_q.fd_cnt + 12'h001;
      end
    end
    if (lr_rise) begin
      c_d.fd_on  = 1'b1;
      c_d.fd_cnt = 12'h000;
    end
    if (REG_WR_EN) begin
      if (REG_ADDR == `ACD_CFG3_OFS) begin
        c_d.cfg3 = REG_WDATA;
      end else if (REG_ADDR == `ACD_STAT_OFS) begin
        c_d.st_wr = 1'b1;
      end else if (REG_ADDR == `ACD_BCNT_LO_OFS || REG_ADDR == `ACD_BCNT_HI_OFS) begin
        c_d.clr_b = ~c_q.clr_b;
      end else if (REG_ADDR == `ACD_ECNT_0_OFS || REG_ADDR == `ACD_ECNT_1_OFS ||
                   REG_ADDR == `ACD_ECNT_2_OFS) begin
        c_d.clr_e = ~c_q.clr_e;
      end
    end
    if (REG_RD_EN) begin
      c_d.rvalid = 1'b1;
      if (REG_ADDR == `ACD_CFG3_OFS) begin
        c_d.rdata = c_q.cfg3;
      end else if (REG_ADDR == `ACD_STAT_OFS) begin
        c_d.rdata = {c_q.pin[5], c_q.pin[4], c_q.pin[3], c_q.auto_rst, 4'h0};
      end else if (REG_ADDR == `ACD_BCNT_LO_OFS) begin
        c_d.rdata = c_q.sh_b[7:0];
      end else if (REG_ADDR == `ACD_BCNT_HI_OFS) begin
        c_d.rdata = {4'h0, c_q.sh_b[11:8]};
      end else if (REG_ADDR == `ACD_ECNT_0_OFS) begin
        c_d.rdata = c_q.sh_e[7:0];
      end else if (REG_ADDR == `ACD_ECNT_1_OFS) begin
        c_d.rdata = c_q.sh_e[15:8];
      end else if (REG_ADDR == `ACD_ECNT_2_OFS) begin
        c_d.rdata = c_q.sh_e[23:16];
      end else begin
        c_d.rdata = 8'h00;
      end
    end
    // reset command from the link restarts the core side
    if (c_ev[0]) begin
      c_d.cfg3     = `ACD_CFG3_RST;
      c_d.auto_rst = 1'b0;
      c_d.fd_on    = 1'b1;
      c_d.fd_cnt   = 12'h000;
    end
    // a timeout in the clearing cycle still sets the flag
    if (c_q.pin[2] && !c_q.cfg3[`ACD_C3_WDOFF]) begin
      c_d.auto_rst = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      c_q       <= '0;
      c_q.cfg3  <= `ACD_CFG3_RST;
      c_q.fd_on <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  assign CMD_OUT               = l_q.out;
  assign FINE_DELAY1           = l_q.fine1;
  assign FINE_DELAY2           = l_q.fine2;
  assign COARSE_DELAY          = l_q.coarse;
  assign CONTROL               = l_q.control;
  assign CHIP_ID               = l_q.chip_id;
  assign CROSSING_COUNT        = l_q.bcnt;
  assign TRIGGER_COUNT         = l_q.ecnt;
  assign REG_RDATA             = c_q.rdata;
  assign REG_RVALID            = c_q.rvalid;
  assign STATUS_WRITE_PULSE    = c_q.st_wr;
  assign FREQ_DETECT_ON        = c_q.fd_on;
  assign FREQ_SPEEDUP_ON       = c_q.fd_on & ~c_q.cfg3[`ACD_C3_NOSPD];
  assign TIMEOUT_GUARD_ON      = ~c_q.cfg3[`ACD_C3_WDOFF];
  assign SCRUBBER_ON           = SCRUBBER_ON_PRIMARY | c_q.cfg3[`ACD_C3_SCRUB];
  assign INBOUND_CORRECTION_ON = c_q.cfg3[`ACD_C3_CORR];
  assign TEST_PINS_ON          = c_q.cfg3[`ACD_C3_TEST];
endmodule : acd_decoder
`default_nettype wire

//--- tb/acd_link_tx.sv
// link transmitter model: command frames and channel pulses
`timescale 1ns/1ps
`default_nettype none
module acd_link_tx (
  // recovered link clock
  input  wire logic           link_clk,
  // frame and channel pulses
  output acd_pkg::acd_frame_t frame,
  output logic                accept,
  output logic                bc_clr,
  output logic                ec_clr
);
  import acd_pkg::*;
  initial begin
    frame = '0;
    {accept, bc_clr, ec_clr} = 3'h0;
  end
  // fields flip after the valid cycle so a stale frame never looks current
  task automatic send(input logic [13:0] t, input logic s, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge link_clk);
    frame <= '{1'b1, t, s, a, d};
    @(posedge link_clk);
    frame <= '{1'b0, ~t, ~s, ~a, ~d};
  endtask : send
  // which: 0 trigger accept, 1 crossing clear, 2 trigger clear
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge link_clk);
      accept <= (which == 0);
      bc_clr <= (which == 1);
      ec_clr <= (which == 2);
      @(posedge link_clk);
      {accept, bc_clr, ec_clr} <= 3'h0;
    end
  endtask : pulse
endmodule : acd_link_tx
`default_nettype wire

//--- tb/acd_decoder_sva.sv
// concurrent checks on the command decoder ports
`timescale 1ns/1ps
`default_nettype none
module acd_decoder_sva (
  // clocks and reset
  input wire logic                CORE_CLK,
  input wire logic                ARST_N,
  input wire logic                LINK_CLK,
  // link side
  input wire acd_pkg::acd_frame_t FRAME,
  input wire logic                CROSSING_COUNT_CLEAR_CMD,
  input wire logic                TRIGGER_COUNT_CLEAR_CMD,
  input wire logic                TRIGGER_ACCEPT,
  input wire acd_pkg::acd_out_t   CMD_OUT,
  input wire logic [13:0]         CHIP_ID,
  input wire logic [11:0]         CROSSING_COUNT,
  input wire logic [23:0]         TRIGGER_COUNT,
  // register side
  input wire logic                REG_WR_EN,
  input wire logic                REG_RD_EN,
  input wire logic [7:0]          REG_ADDR,
  input wire logic [7:0]          REG_WDATA,
  input wire logic [7:0]          REG_RDATA,
  input wire logic                REG_RVALID,
  input wire logic                STATUS_WRITE_PULSE,
  input wire logic                SCRUBBER_ON_PRIMARY,
  input wire logic                FREQ_SPEEDUP_ON,
  input wire logic                TIMEOUT_GUARD_ON,
  input wire logic                SCRUBBER_ON
);
  import acd_pkg::*;
  logic hit;
  // readout and id-load windows are not modelled, the bench keeps out of them
  assign hit = FRAME.valid && (FRAME.target == CHIP_ID || FRAME.target == 14'h0);
  ext_strobe_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    hit && FRAME.scope |=> CMD_OUT.strobe && CMD_OUT.index == $past(FRAME.sub)
      && CMD_OUT.data == $past(FRAME.data) && CMD_OUT.qual == 4'h0)
    else $error("external command not forwarded");
  dump_start_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    hit && !FRAME.scope && FRAME.sub inside {8'h04, 8'h05} |-> ##2 CMD_OUT.strobe
      && CMD_OUT.qual == (($past(FRAME.sub, 2) == 8'h04) ? 4'h1 : 4'h5))
    else $error("readout did not start");
  dump_step_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    CMD_OUT.strobe && CMD_OUT.qual inside {[4'h1:4'h3], [4'h5:4'h9]}
      |=> CMD_OUT.strobe && CMD_OUT.qual == $past(CMD_OUT.qual) + 4'h1)
    else $error("readout sequence broken");
  high_sub_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    hit && !FRAME.scope && FRAME.sub > 8'h06 |=> !CMD_OUT.strobe)
    else $error("unused index produced output");
  miss_id_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    FRAME.valid && FRAME.target != CHIP_ID && FRAME.target != 14'h0 |=> !CMD_OUT.strobe)
    else $error("foreign frame produced output");
  bcnt_clr_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    CROSSING_COUNT_CLEAR_CMD |=> CROSSING_COUNT == 12'h0)
    else $error("crossing count not cleared");
  bcnt_run_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    1'b1 |=> CROSSING_COUNT == $past(CROSSING_COUNT) + 12'h1 || CROSSING_COUNT == 12'h0)
    else $error("crossing count did not advance");
  ecnt_clr_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    TRIGGER_COUNT_CLEAR_CMD |=> TRIGGER_COUNT == 24'h0)
    else $error("trigger count not cleared");
  ecnt_inc_a: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
    TRIGGER_ACCEPT && !TRIGGER_COUNT_CLEAR_CMD
      |=> TRIGGER_COUNT == $past(TRIGGER_COUNT) + 24'h1 || TRIGGER_COUNT == 24'h0)
    else $error("trigger count did not advance");
  stat_zero_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    REG_RD_EN && REG_ADDR == 8'h16 |=> REG_RVALID && REG_RDATA[3:0] == 4'h0)
    else $error("health low bits not zero");
  stat_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    REG_WR_EN && REG_ADDR == 8'h16 |=> STATUS_WRITE_PULSE)
    else $error("health write gave no pulse");
  guard_bit_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    REG_WR_EN && REG_ADDR == 8'h15 |=> TIMEOUT_GUARD_ON == !$past(REG_WDATA[4]))
    else $error("guard enable wrong");
  no_speedup_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    REG_WR_EN && REG_ADDR == 8'h15 && REG_WDATA[3] |=> !FREQ_SPEEDUP_ON)
    else $error("speed-up not suppressed");
  scrub_on_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    SCRUBBER_ON_PRIMARY |-> SCRUBBER_ON)
    else $error("scrubber off with primary enable");
endmodule : acd_decoder_sva
bind acd_decoder acd_decoder_sva chk (.CORE_CLK, .ARST_N, .LINK_CLK, .FRAME,
  .CROSSING_COUNT_CLEAR_CMD, .TRIGGER_COUNT_CLEAR_CMD, .TRIGGER_ACCEPT, .CMD_OUT, .CHIP_ID,
  .CROSSING_COUNT, .TRIGGER_COUNT, .REG_WR_EN, .REG_RD_EN, .REG_ADDR, .REG_WDATA, .REG_RDATA,
  .REG_RVALID, .STATUS_WRITE_PULSE, .SCRUBBER_ON_PRIMARY, .FREQ_SPEEDUP_ON, .TIMEOUT_GUARD_ON,
  .SCRUBBER_ON);
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the addressed command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin error_cnt++; \
  $display("wrong value at %0t: %h expected %h", $time, act, exp); end end
module testbench;
  import acd_pkg::*;
  // nets named as the ports so the instance connects by name
  logic CORE_CLK = 1'b0, LINK_CLK = 1'b0, ARST_N = 1'b0, REG_WR_EN = 1'b0, REG_RD_EN = 1'b0;
  logic WDOG_TIMEOUT = 1'b0, FRAME_SYNC = 1'b0, PHASE_OK = 1'b0, CDR_LOCK = 1'b0;
  logic SCRUBBER_ON_PRIMARY = 1'b0, FREQ_LOW = 1'b0, LOOP_RESET = 1'b0, ID_BOOT_SEL = 1'b0;
  logic [15:0] ID_STRAP = 16'h2a5c;
  logic [13:0] ID_BOOT = 14'h1234;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
  acd_frame_t FRAME;
  acd_errcnt_t ERR_COUNTS;
  acd_out_t CMD_OUT;
  logic CROSSING_COUNT_CLEAR_CMD, TRIGGER_COUNT_CLEAR_CMD, TRIGGER_ACCEPT, REG_RVALID;
  logic STATUS_WRITE_PULSE, FREQ_DETECT_ON, FREQ_SPEEDUP_ON, TIMEOUT_GUARD_ON, SCRUBBER_ON;
  logic INBOUND_CORRECTION_ON, TEST_PINS_ON;
  logic [7:0] FINE_DELAY1, FINE_DELAY2, COARSE_DELAY, CONTROL, REG_RDATA;
  logic [13:0] CHIP_ID;
  logic [11:0] CROSSING_COUNT, b;
  logic [23:0] TRIGGER_COUNT;
  logic [7:0] m [4];
  logic [7:0] e [10];
  logic [13:0] id;
  logic [31:0] rnd;
  logic [2:0] st;
  int cyc = 0, r0 = 0, error_cnt = 0, comparisons = 0;
  acd_decoder uut (.CORE_CLK, .ARST_N, .LINK_CLK, .FRAME, .CROSSING_COUNT_CLEAR_CMD,
    .TRIGGER_COUNT_CLEAR_CMD, .TRIGGER_ACCEPT, .ERR_COUNTS, .ID_STRAP, .ID_BOOT_SEL,
    .ID_BOOT, .CMD_OUT, .FINE_DELAY1, .FINE_DELAY2, .COARSE_DELAY, .CONTROL, .CHIP_ID,
    .CROSSING_COUNT, .TRIGGER_COUNT, .REG_WR_EN, .REG_RD_EN, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .REG_RVALID, .STATUS_WRITE_PULSE, .FREQ_LOW, .LOOP_RESET, .WDOG_TIMEOUT,
    .FRAME_SYNC, .PHASE_OK, .CDR_LOCK, .SCRUBBER_ON_PRIMARY, .FREQ_DETECT_ON,
    .FREQ_SPEEDUP_ON, .TIMEOUT_GUARD_ON, .SCRUBBER_ON, .INBOUND_CORRECTION_ON,
    .TEST_PINS_ON);
  acd_link_tx tx (.link_clk(LINK_CLK), .frame(FRAME), .accept(TRIGGER_ACCEPT),
    .bc_clr(CROSSING_COUNT_CLEAR_CMD), .ec_clr(TRIGGER_COUNT_CLEAR_CMD));
  initial forever #5 CORE_CLK = ~CORE_CLK;
  initial begin
    #3;
    forever #24 LINK_CLK = ~LINK_CLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic nx();
    rnd = lfsr(rnd);
  endtask : nx
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic lk(input int n);
    repeat (n) @(posedge LINK_CLK);
    #1;
  endtask : lk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR_EN <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR_EN <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge CORE_CLK);
    REG_RD_EN <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD_EN <= 1'b0;
    #1;
    `CHK({REG_RVALID, REG_RDATA}, {1'b1, x})
  endtask : rd
  // internal frame, then all four timing registers against the model
  task automatic iw(input logic [13:0] t, input logic [7:0] a, input logic [7:0] d);
    tx.send(t, 1'b0, a, d);
    if (a < 8'h04 && (t == id || t == 14'h0))
      m[a[1:0]] = d;
    lk(1);
    `CHK({FINE_DELAY1, FINE_DELAY2, COARSE_DELAY, CONTROL}, {m[0], m[1], m[2], m[3]})
  endtask : iw
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    rnd = 32'hc930;
    nx();
    ERR_COUNTS = rnd;
    id = ID_STRAP[13:0];
    m = '{default: 8'h00};
    repeat (6) @(posedge LINK_CLK);
    ARST_N <= 1'b1;
    r0 = cyc;
    lk(3);
    `CHK(CHIP_ID, id)
    rd(8'h15, 8'ha7);
    nx();
    st = rnd[2:0];
    @(posedge CORE_CLK) {CDR_LOCK, PHASE_OK, FRAME_SYNC} <= st;
    repeat (8) @(posedge CORE_CLK);
    rd(8'h16, {st, 5'h00});
    wr(8'h16, 8'hff);
    rd(8'h16, {st, 5'h00});
    rd(8'h40, 8'h00);
    for (int i = 0; i < 8; i++) begin
      nx();
      iw(i[0] ? id : 14'h0, {6'h00, i[1:0]}, rnd[7:0]);
    end
    iw(id ^ 14'h1, 8'h00, ~m[0]);
    iw(id, 8'h07 + {1'b0, rnd[14:8]}, ~m[1]);
    tx.send(id, 1'b1, rnd[23:16], rnd[31:24]);
    #1;
    `CHK(CMD_OUT, {rnd[23:16], rnd[31:24], 4'h0, 1'b1})
    e = '{ERR_COUNTS.single[7:0], ERR_COUNTS.single[15:8], ERR_COUNTS.dbl, ERR_COUNTS.seu,
          m[0], m[1], m[2], m[3], id[7:0], {2'b00, id[13:8]}};
    for (int k = 0; k < 2; k++) begin
      tx.send(id, 1'b0, 8'h04 + 8'(k), rnd[7:0]);
      for (int j = 0; j < (k ? 6 : 4); j++) begin
        lk(1);
        `CHK({CMD_OUT.data, CMD_OUT.qual, CMD_OUT.strobe}, {e[j + 4*k], 4'(1 + j + 4*k), 1'b1})
      end
    end
    lk(1);
    b = CROSSING_COUNT;
    lk(5);
    `CHK(CROSSING_COUNT, 12'(b + 12'd5))
    tx.pulse(1, 1);
    #1;
    `CHK(CROSSING_COUNT, 12'h0)
    tx.pulse(2, 1);
    nx();
    tx.pulse(0, rnd[2:0] + 1);
    #1;
    `CHK(TRIGGER_COUNT, 24'(rnd[2:0] + 1))
    lk(20);
    rd(8'h19, 8'(rnd[2:0] + 1));
    wr(8'h1a, 8'h00);
    lk(8);
    `CHK(TRIGGER_COUNT, 24'h0)
    wr(8'h18, 8'h00);
    lk(8);
    `CHK(CROSSING_COUNT < 12'd10, 1'b1)
    // detection began at release with n at its default of seven
    while (cyc < r0 + 2040) @(posedge CORE_CLK);
    #1;
    `CHK(FREQ_DETECT_ON, 1'b1)
    while (cyc < r0 + 2064) @(posedge CORE_CLK);
    #1;
    `CHK(FREQ_DETECT_ON, 1'b0)
    for (int i = 0; i < 4; i++) begin
      nx();
      @(posedge CORE_CLK) SCRUBBER_ON_PRIMARY <= rnd[8];
      wr(8'h15, rnd[7:0]);
      rd(8'h15, rnd[7:0]);
      `CHK({TIMEOUT_GUARD_ON, INBOUND_CORRECTION_ON, TEST_PINS_ON, SCRUBBER_ON}, {~rnd[4], rnd[5], rnd[6], rnd[7] | rnd[8]})
    end
    wr(8'h15, 8'ha7);
    @(posedge CORE_CLK) WDOG_TIMEOUT <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    rd(8'h16, {st, 5'h10});
    @(posedge CORE_CLK) WDOG_TIMEOUT <= 1'b0;
    wr(8'h15, 8'h00);
    ID_BOOT_SEL <= 1'b1;
    tx.send(id, 1'b0, 8'h06, 8'hff);
    m = '{default: 8'h00};
    lk(10);
    `CHK({CHIP_ID, FINE_DELAY1, CONTROL, CROSSING_COUNT < 12'd12}, {ID_BOOT, 16'h0, 1'b1})
    rd(8'h15, 8'ha7);
    rd(8'h16, {st, 5'h00});
    `CHK({FREQ_DETECT_ON, FREQ_SPEEDUP_ON}, 2'b11)
    wr(8'h15, 8'ha8);
    #1;
    `CHK(FREQ_SPEEDUP_ON, 1'b0)
    // loop reset restarts detection, a held low-frequency flag keeps it running
    @(posedge CORE_CLK) {FREQ_LOW, LOOP_RESET} <= 2'b11;
    repeat (30) @(posedge CORE_CLK);
    #1;
    `CHK(FREQ_DETECT_ON, 1'b1)
    @(posedge CORE_CLK) FREQ_LOW <= 1'b0;
    repeat (30) @(posedge CORE_CLK);
    #1;
    `CHK(FREQ_DETECT_ON, 1'b0)
    conclude();
  end
endmodule : testbench
`default_nettype wire
